// file: bench/board_clocker.sv
// board logic model: raises clock terms or the clock pin on request
module board_clocker (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        fire,
  input  wire logic        use_pin,
  input  wire logic [19:0] mask,
  output logic      [19:0] clk_terms,
  output logic             clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  // low while busy, one setup cycle, then two cycles high
  always_ff @(posedge clk) begin
    if (busy) phase <= 2'h0;
    else if (fire) phase <= 2'h1;
    else if (phase != 2'h0) phase <= phase + 2'h1;
  end
  assign clk_terms = (phase[1] && !use_pin) ? mask : 20'h00000;
  assign clk_pin = phase[1] && use_pin;
endmodule

// file: bench/logic_cell_sva.sv
// port assertions for the dual register logic cell
module logic_cell_sva #(
  parameter int POWER_UP_RESET_CYCLES = 4
) (
  // clock and bus
  input wire logic                      CLK,
  input wire logic                      SRST,
  input wire logic                      WB_CYC_I,
  input wire logic                      WB_STB_I,
  input wire logic                      WB_ACK_O,
  // array side
  input wire logic_cell_pkg::terms_type TERMS,
  input wire logic                      CLOCK_PIN,
  input wire logic                      SYNC_PRESET,
  input wire logic                      PRELOAD_HV,
  input wire logic [9:0]                OE_TERM,
  input wire logic [9:0]                IO_IN,
  input wire logic [9:0]                IO_OE,
  input wire logic [9:0]                PIN_FEEDBACK,
  input wire logic [19:0]               REG_FEEDBACK,
  input wire logic                      POWER_UP_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  int up_cnt;
  int quiet_cnt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // busy cycles since release of reset
  always_ff @(posedge CLK) begin
    if (SRST) up_cnt <= 0;
    else if (POWER_UP_BUSY) up_cnt <= up_cnt + 1;
  end
  // cycles with no clock, reset term or bus traffic; state must then rest
  always_ff @(posedge CLK) begin
    if (SRST || TERMS.clock != '0 || CLOCK_PIN || TERMS.reset != '0 || WB_CYC_I) quiet_cnt <= 0;
    else if (quiet_cnt < 7) quiet_cnt <= quiet_cnt + 1;
  end
  a_ack_after_req: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_oe_term_pass: assert property (IO_OE == OE_TERM)
    else $error("pin enable differs from its term");
  a_pin_input_path: assert property (PIN_FEEDBACK == IO_IN)
    else $error("pin feedback differs from pin");
  a_reset_term_clears: assert property ((REG_FEEDBACK & $past(TERMS.reset)) == '0)
    else $error("register not cleared by reset term");
  a_power_up_clear: assert property (disable iff (1'b0) SRST |=> REG_FEEDBACK == '0)
    else $error("registers not cleared by power-up reset");
  a_busy_length: assert property ($fell(POWER_UP_BUSY) |->
      (up_cnt >= POWER_UP_RESET_CYCLES - 1 && up_cnt <= POWER_UP_RESET_CYCLES + 1))
    else $error("power-up interval has wrong length");
  a_state_rests: assert property (quiet_cnt >= 3 |-> $stable(REG_FEEDBACK))
    else $error("register changed with no clock");
  c_preload: cover property (PRELOAD_HV && TERMS.clock != '0);
  c_preset: cover property (SYNC_PRESET && TERMS.clock != '0);
  c_power_up: cover property ($fell(POWER_UP_BUSY));
endmodule

bind logic_cell logic_cell_sva #(.POWER_UP_RESET_CYCLES(POWER_UP_RESET_CYCLES)) i_sva (
  .CLK, .SRST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .TERMS, .CLOCK_PIN, .SYNC_PRESET,
  .PRELOAD_HV, .OE_TERM, .IO_IN, .IO_OE, .PIN_FEEDBACK, .REG_FEEDBACK, .POWER_UP_BUSY);

// file: bench/testbench.sv
// self-checking bench for the dual register logic cell
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst, cyc, stb, we, ack, clk_pin, preset, hv, psel, keeper, busy, fire, use_pin;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [19:0] sum, rst, ctm, mask, reg_fb;
  logic [9:0] oe, io_in, io_out, io_oe, pin_fb;
  logic_cell_pkg::terms_type terms;
  int fails, checks_done;
  assign terms = {sum, rst, ctm};
  // 250 MHz clock
  always #2 clk = ~clk;
  logic_cell #(.POWER_UP_RESET_CYCLES(4)) i_dut (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TERMS(terms), .CLOCK_PIN(clk_pin),
    .SYNC_PRESET(preset), .OE_TERM(oe), .PRELOAD_HV(hv), .PRELOAD_SEL(psel), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .PIN_KEEPER_EN(keeper), .PIN_FEEDBACK(pin_fb),
    .REG_FEEDBACK(reg_fb), .POWER_UP_BUSY(busy));
  board_clocker i_board (.clk(clk), .busy(busy), .fire(fire), .use_pin(use_pin),
    .mask(mask), .clk_terms(ctm), .clk_pin(clk_pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [19:0] m, input logic p);
    mask <= m;
    use_pin <= p;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset;
    chk(reg_fb, 0);
    chk(io_out, 0);
    chk(io_oe, 10'h2A5);
    chk(pin_fb, 10'h0C3);
    chk(busy, 1'b0);
    rdchk(logic_cell_pkg::TIMER_OFFSET, 32'h00000000);
    rdchk(logic_cell_pkg::TTYPE_OFFSET, logic_cell_pkg::TTYPE_RESET);
    rdchk(8'h40, 0);
    $display("test reset done");
  endtask
  task automatic t_flops;
    wb(1'b1, logic_cell_pkg::TTYPE_OFFSET, 32'h00000400);
    sum <= 20'h00403;
    pulse(20'h00401, 1'b0);
    chk(reg_fb, 20'h00401);
    pulse(20'h00401, 1'b0);
    chk(reg_fb, 20'h00001);
    sum <= 20'h00000;
    pulse(20'hFFFFF, 1'b0);
    chk(reg_fb, 20'h00000);
    wb(1'b1, logic_cell_pkg::PINCLK_OFFSET, 32'h00000004);
    sum <= 20'h00004;
    pulse(20'h00000, 1'b1);
    chk(reg_fb, 20'h00004);
    rdchk(logic_cell_pkg::STATE_OFFSET, 32'h00000004);
    rst <= 20'h00004;
    repeat (2) @(posedge clk);
    chk(reg_fb, 20'h00000);
    rst <= 20'h00000;
    wb(1'b1, logic_cell_pkg::PINCLK_OFFSET, 32'h00000000);
    wb(1'b1, logic_cell_pkg::TTYPE_OFFSET, 32'h00000000);
    wb(1'b1, logic_cell_pkg::POLARITY_OFFSET, 32'h000003FF);
    chk(io_out, 10'h3FF);
    $display("test flops done");
  endtask
  task automatic t_preload;
    hv <= 1'b1;
    io_in <= 10'h155;
    pulse(20'hFFFFF, 1'b0);
    chk(reg_fb, 20'h00155);
    psel <= 1'b1;
    io_in <= 10'h0F0;
    pulse(20'hFFFFF, 1'b0);
    chk(reg_fb, 20'h3C155);
    chk(io_out, 10'h2AA);
    hv <= 1'b0;
    pulse(20'hFFFFF, 1'b0);
    chk(reg_fb, 20'h00004);
    $display("test preload done");
  endtask
  task automatic t_preset;
    preset <= 1'b1;
    rst <= 20'h00001;
    pulse(20'hFFFFF, 1'b0);
    chk(reg_fb, 20'hFFFFE);
    preset <= 1'b0;
    rst <= 20'h00000;
    $display("test preset done");
  endtask
  task automatic t_modes;
    wb(1'b1, logic_cell_pkg::SIGNATURE_OFFSET, 32'h12345678);
    rdchk(logic_cell_pkg::SIGNATURE_OFFSET, 32'h12345678);
    wb(1'b1, logic_cell_pkg::CTRL_OFFSET, 32'h00000002);
    chk(keeper, 1'b1);
    wb(1'b1, logic_cell_pkg::CTRL_OFFSET, 32'h00000003);
    chk(keeper, 1'b0);
    rdchk(logic_cell_pkg::SIGNATURE_OFFSET, 0);
    chk(reg_fb, 20'h003FE);
    wb(1'b1, logic_cell_pkg::TTYPE_OFFSET, 32'h00000001);
    sum <= 20'h00001;
    pulse(20'h00001, 1'b0);
    pulse(20'h00001, 1'b0);
    chk(reg_fb, 20'h003FF);
    wb(1'b1, logic_cell_pkg::CTRL_OFFSET, 32'h00000004);
    rdchk(logic_cell_pkg::CTRL_OFFSET, 32'h00000007);
    rdchk(logic_cell_pkg::POLARITY_OFFSET, 32'h000003FF);
    rdchk(logic_cell_pkg::SIGNATURE_OFFSET, 32'hFFFFFFFF);
    $display("test modes done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: tests need well under 2000 cycles
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  // main sequence; busy lasts 4 cycles, so 8 is a fixed margin
  initial begin
    {cyc, stb, we, preset, hv, psel, fire, use_pin} = '0;
    {adr, wdat, sum, rst, mask} = '0;
    sel = 4'hF;
    oe = 10'h2A5;
    io_in = 10'h0C3;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_flops();
    t_preload();
    t_preset();
    t_modes();
    end_sim();
  end
endmodule

// file: inc/logic_cell_pkg.sv
// package for the dual register logic cell: sizes, register map, reset values, timing
package logic_cell_pkg;

  // geometry
  localparam int CELLS = 10;
  localparam int REGS  = 2 * CELLS;

  // wishbone register byte offsets
  localparam logic [7:0] CTRL_OFFSET      = 8'h00;
  localparam logic [7:0] TTYPE_OFFSET     = 8'h04;
  localparam logic [7:0] PINCLK_OFFSET    = 8'h08;
  localparam logic [7:0] POLARITY_OFFSET  = 8'h0C;
  localparam logic [7:0] SIGNATURE_OFFSET = 8'h10;
  localparam logic [7:0] STATE_OFFSET     = 8'h14;
  localparam logic [7:0] TIMER_OFFSET     = 8'h18;

  // control register field positions
  localparam int CTRL_LEGACY_BIT = 0;
  localparam int CTRL_KEEPER_BIT = 1;
  localparam int CTRL_SECURE_BIT = 2;

  // reset values
  localparam logic [REGS-1:0]  TTYPE_RESET     = 20'h00000;
  localparam logic [REGS-1:0]  PINCLK_RESET    = 20'h00000;
  localparam logic [CELLS-1:0] POLARITY_RESET  = 10'h000;
  localparam logic [31:0]      SIGNATURE_RESET = 32'h00000000;

  // power-up reset interval: longest time, rounded down to clock cycles
  localparam int CLK_PERIOD_PS            = 4000;
  localparam int POWER_UP_RESET_INTERVAL_NS = 1000;
  localparam int POWER_UP_RESET_CYCLES =
    (POWER_UP_RESET_INTERVAL_NS * 1000) / CLK_PERIOD_PS;

  // configuration fuses as software sees them
  typedef struct packed {
    logic             legacy;
    logic             keeper;
    logic             secure;
    logic [REGS-1:0]  ttype;
    logic [REGS-1:0]  pinclk;
    logic [CELLS-1:0] polarity;
    logic [31:0]      signature;
  } cfg_type;

  // per-register array terms presented to the cell
  typedef struct packed {
    logic [REGS-1:0] sum;
    logic [REGS-1:0] reset;
    logic [REGS-1:0] clock;
  } terms_type;

endpackage

// file: rtl/logic_cell.sv
// dual register output logic cells with wishbone configuration port
// Functional notes
// R1 - On power-up reset every register clears low with no clock needed.
// R2 - Registered pin level equals cleared register combined with output polarity.
// R3 - Outside logic keeps clocks stable during the power-up reset interval.
// R4 - Outside logic meets setup before driving any clock high after reset.
// R5 - Each flip-flop individually selects D-type or T-type behaviour.
// R6 - Each flip-flop selects its clock term or the dedicated clock pin.
// R7 - Two flip-flops per cell, twenty registers in all.
// R8 - Each register has its own sum, reset and clock terms.
// R9 - Every pin has its own input path; every register its own feedback.
// R10 - Each pin driver enabled by its own output enable term.
// R11 - One synchronous preset shared by all registers sets them high.
// R12 - Outside logic raises internal clocks and meets timing during preset.
// R13 - Each register's reset term clears it at once, regardless of clock.
// R14 - After security fuse is set every configuration fuse reads as programmed.
// R15 - Programming flow sets the security fuse last.
// R16 - Preload forces register to pin level, independent of output polarity.
// R17 - Preload clock pulse loads register 0 or 1 by select; other keeps value.
// R18 - Preload only while supervoltage detect input is asserted.
// R19 - Legacy mode: no T-type, no pin clocking, no second register feedback.
// R20 - Legacy mode: signature row reads zero and pin-keeper is disabled.
// R21 - T-type toggles on an active edge when sum term is one, else holds.
// R22 - Reset term beats preset acting on the same register.
module logic_cell #(
  parameter int CELLS = logic_cell_pkg::CELLS,
  parameter int REGS  = logic_cell_pkg::REGS,
  parameter int POWER_UP_RESET_CYCLES = logic_cell_pkg::POWER_UP_RESET_CYCLES
) (
  // clock and power-up reset
  input  wire logic                       CLK,
  input  wire logic                       SRST,
  // wishbone slave
  input  wire logic                       WB_CYC_I,
  input  wire logic                       WB_STB_I,
  input  wire logic                       WB_WE_I,
  input  wire logic [7:0]                 WB_ADR_I,
  input  wire logic [3:0]                 WB_SEL_I,
  input  wire logic [31:0]                WB_DAT_I,
  output logic      [31:0]                WB_DAT_O,
  output logic                            WB_ACK_O,
  // array terms and shared controls
  input  wire logic_cell_pkg::terms_type  TERMS,
  input  wire logic                       CLOCK_PIN,
  input  wire logic                       SYNC_PRESET,
  input  wire logic [CELLS-1:0]           OE_TERM,
  // preload test controls
  input  wire logic                       PRELOAD_HV,
  input  wire logic                       PRELOAD_SEL,
  // i/o pins
  input  wire logic [CELLS-1:0]           IO_IN,
  output logic      [CELLS-1:0]           IO_OUT,
  output logic      [CELLS-1:0]           IO_OE,
  output logic                            PIN_KEEPER_EN,
  // paths back into the array
  output logic      [CELLS-1:0]           PIN_FEEDBACK,
  output logic      [REGS-1:0]            REG_FEEDBACK,
  output logic                            POWER_UP_BUSY
);

  logic_cell_pkg::cfg_type cfg;
  logic [REGS-1:0]  state;
  logic [REGS-1:0]  next_state;
  logic [REGS-1:0]  live_state;
  logic [REGS-1:0]  clock_term_prev;
  logic             clock_pin_prev;
  logic [REGS-1:0]  edge_hit;
  logic [REGS-1:0]  ttype_eff;
  logic [REGS-1:0]  pinclk_eff;
  logic [15:0]      pur_count;
  logic             pur_busy;
  logic [31:0]      read_value;
  logic [31:0]      signature_eff;
  logic             wb_req;
  logic             wb_write;
  logic             legacy_fuse;
  logic             keeper_fuse;
  logic             secure_fuse;
  logic [REGS-1:0]  ttype_fuse;
  logic [REGS-1:0]  pinclk_fuse;
  logic [CELLS-1:0] polarity_fuse;
  logic [31:0]      signature_fuse;
  logic [31:0]      ttype_word;
  logic [31:0]      pinclk_word;
  logic [31:0]      polarity_word;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction

  // one register's value after an active clock edge
  function automatic logic step(input logic q,
                                input logic sum,
                                input logic ttype);
    // R21 toggle or hold
    if (ttype) begin
      return q ^ sum;
    end
    return sum;
  endfunction

  // legacy subset masks the extended fuses
  // R19 legacy subset
  assign ttype_eff  = cfg.legacy ? '0 : cfg.ttype;
  assign pinclk_eff = cfg.legacy ? '0 : cfg.pinclk;

  // power-up reset interval: clock edges are not acted on while it runs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pur_count <= 16'(POWER_UP_RESET_CYCLES);
    end else if (pur_count != 16'h0000) begin
      pur_count <= pur_count - 16'h0001;
    end
  end
  assign pur_busy      = (pur_count != 16'h0000);
  assign POWER_UP_BUSY = pur_busy;

  // previous levels of every clock source for edge detection
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clock_term_prev <= '0;
      clock_pin_prev  <= 1'b0;
    end else begin
      clock_term_prev <= TERMS.clock;
      clock_pin_prev  <= CLOCK_PIN;
    end
  end

  // active edge per register from its chosen source
  always_comb begin
    for (int r = 0; r < REGS; r++) begin
      // R6 clock source select
      if (pinclk_eff[r]) begin
        edge_hit[r] = CLOCK_PIN & ~clock_pin_prev;
      end else begin
        // R8 own clock term
        edge_hit[r] = TERMS.clock[r] & ~clock_term_prev[r];
      end
      // R3 edges ignored during interval
      if (pur_busy) begin
        edge_hit[r] = 1'b0;
      end
    end
  end

  // next value of all twenty registers
  always_comb begin
    next_state = state;
    for (int r = 0; r < REGS; r++) begin
      if (edge_hit[r]) begin
        if (PRELOAD_HV) begin
          // R18 preload under supervoltage
          // R17 select picks the register
          if ((r >= CELLS) == PRELOAD_SEL) begin
            // R16 pin level, no polarity
            next_state[r] = IO_IN[r % CELLS];
          end
        end else if (SYNC_PRESET) begin
          // R11 shared preset sets high
          next_state[r] = 1'b1;
        end else begin
          // R5 d or t behaviour
          next_state[r] = step(state[r], TERMS.sum[r], ttype_eff[r]);
        end
      end
      // R22 reset beats preset
      // R13 individual reset clears
      if (TERMS.reset[r]) begin
        next_state[r] = 1'b0;
      end
    end
  end

  // the twenty flip-flops, two per cell
  always_ff @(posedge CLK) begin
    // R7 two per cell
    // R1 power-up clear
    if (SRST) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // reset term also masks the stored value at once, so clear needs no edge
  // R13 immediate clear
  assign live_state = state & ~TERMS.reset;

  // registered outputs through the programmable polarity
  // R2 polarity after reset
  assign IO_OUT = live_state[CELLS-1:0] ^ cfg.polarity;

  // R10 per-pin enable term
  assign IO_OE = OE_TERM;

  // R9 dedicated input path
  assign PIN_FEEDBACK = IO_IN;

  // second register feedback is absent in the legacy subset
  // R19 no second feedback
  assign REG_FEEDBACK = {live_state[REGS-1:CELLS] & {CELLS{~cfg.legacy}},
                         live_state[CELLS-1:0]};

  // R20 keeper off in legacy
  assign PIN_KEEPER_EN = cfg.keeper & ~cfg.legacy;

  // R20 signature forced zero
  assign signature_eff = cfg.legacy ? 32'h00000000 : cfg.signature;

  // wishbone strobes: write lands on the edge where ack is seen high
  assign wb_req   = WB_CYC_I & WB_STB_I;
  assign wb_write = wb_req & WB_ACK_O & WB_WE_I;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
    end
  end

  // fuse rows gathered into one carrier; each row has a single writer below
  assign cfg = {legacy_fuse, keeper_fuse, secure_fuse, ttype_fuse, pinclk_fuse,
                polarity_fuse, signature_fuse};

  // control fuses; security is sticky until power-up reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      legacy_fuse <= 1'b0;
      keeper_fuse <= 1'b0;
      secure_fuse <= 1'b0;
    end else if (wb_write && WB_ADR_I == logic_cell_pkg::CTRL_OFFSET && WB_SEL_I[0]) begin
      legacy_fuse <= WB_DAT_I[logic_cell_pkg::CTRL_LEGACY_BIT];
      keeper_fuse <= WB_DAT_I[logic_cell_pkg::CTRL_KEEPER_BIT];
      secure_fuse <= secure_fuse | WB_DAT_I[logic_cell_pkg::CTRL_SECURE_BIT];
    end
  end

  // byte-lane merged write words; only the low bits are real fuses
  assign ttype_word    = merge(32'(ttype_fuse), WB_DAT_I, WB_SEL_I);
  assign pinclk_word   = merge(32'(pinclk_fuse), WB_DAT_I, WB_SEL_I);
  assign polarity_word = merge(32'(polarity_fuse), WB_DAT_I, WB_SEL_I);

  // per-register configuration words
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ttype_fuse    <= logic_cell_pkg::TTYPE_RESET;
      pinclk_fuse   <= logic_cell_pkg::PINCLK_RESET;
      polarity_fuse <= logic_cell_pkg::POLARITY_RESET;
    end else if (wb_write) begin
      unique case (WB_ADR_I)
        logic_cell_pkg::TTYPE_OFFSET: begin
          ttype_fuse <= ttype_word[REGS-1:0];
        end
        logic_cell_pkg::PINCLK_OFFSET: begin
          pinclk_fuse <= pinclk_word[REGS-1:0];
        end
        logic_cell_pkg::POLARITY_OFFSET: begin
          polarity_fuse <= polarity_word[CELLS-1:0];
        end
        default: begin
          ttype_fuse <= ttype_fuse;
        end
      endcase
    end
  end

  // user signature row; legacy load writes zeros into it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      signature_fuse <= logic_cell_pkg::SIGNATURE_RESET;
    end else if (legacy_fuse) begin
      signature_fuse <= 32'h00000000;
    end else if (wb_write && WB_ADR_I == logic_cell_pkg::SIGNATURE_OFFSET) begin
      signature_fuse <= merge(signature_fuse, WB_DAT_I, WB_SEL_I);
    end
  end

  // read mux; fuse words all read as ones once secured
  always_comb begin
    unique case (WB_ADR_I)
      logic_cell_pkg::CTRL_OFFSET: begin
        read_value = {29'h0000000, cfg.secure, cfg.keeper, cfg.legacy};
      end
      logic_cell_pkg::TTYPE_OFFSET: begin
        read_value = 32'(cfg.ttype);
      end
      logic_cell_pkg::PINCLK_OFFSET: begin
        read_value = 32'(cfg.pinclk);
      end
      logic_cell_pkg::POLARITY_OFFSET: begin
        read_value = 32'(cfg.polarity);
      end
      logic_cell_pkg::SIGNATURE_OFFSET: begin
        read_value = signature_eff;
      end
      logic_cell_pkg::STATE_OFFSET: begin
        read_value = 32'(live_state);
      end
      logic_cell_pkg::TIMER_OFFSET: begin
        read_value = {16'h0000, pur_count};
      end
      default: begin
        read_value = 32'h00000000;
      end
    endcase
    // R14 secured fuses read programmed
    if (cfg.secure) begin
      unique case (WB_ADR_I)
        logic_cell_pkg::TTYPE_OFFSET: begin
          read_value = 32'({REGS{1'b1}});
        end
        logic_cell_pkg::PINCLK_OFFSET: begin
          read_value = 32'({REGS{1'b1}});
        end
        logic_cell_pkg::POLARITY_OFFSET: begin
          read_value = 32'({CELLS{1'b1}});
        end
        logic_cell_pkg::SIGNATURE_OFFSET: begin
          read_value = 32'hFFFFFFFF;
        end
        logic_cell_pkg::CTRL_OFFSET: begin
          read_value = 32'h00000007;
        end
        default: begin
          read_value = read_value;
        end
      endcase
    end
  end

  // read data captured as the ack is raised, held otherwise
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WB_DAT_O <= 32'h00000000;
    end else if (wb_req && !WB_ACK_O && !WB_WE_I) begin
      WB_DAT_O <= read_value;
    end
  end

endmodule
